// ---- verification/rfb_modem_model.sv ----
// Far-side modem model: takes transmit bits, plays receive frames
`timescale 1ns/1ps
module rfb_modem_model (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic slow,
   input  wire logic tx_bit,
   input  wire logic tx_bit_valid,
   output logic      tx_bit_ready,
   output logic      rx_bit,
   output logic      rx_bit_valid,
   output logic      rx_frame_end
);
   logic [31:0] cap;
   int          ncap;
   initial begin
      tx_bit_ready = 1'b0;
      rx_bit = 1'b0;
      rx_bit_valid = 1'b0;
      rx_frame_end = 1'b0;
   end
   // Slow mode offers ready every other cycle so the sender must hold
   always @(posedge aclk) begin
      if (!aresetn) begin
         tx_bit_ready <= 1'b0;
         ncap <= 0;
         cap <= 32'h0;
      end else begin
         tx_bit_ready <= slow ? ~tx_bit_ready : 1'b1;
         if (tx_bit_valid && tx_bit_ready) begin
            cap[ncap] <= tx_bit;
            ncap <= ncap + 1;
         end
      end
   end
   task automatic send(input logic [15:0] b, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge aclk);
         rx_bit <= b[i];
         rx_bit_valid <= 1'b1;
      end
      @(posedge aclk);
      // Idle line shows the inverse of the last bit, never a stale copy
      rx_bit <= ~b[n-1];
      rx_bit_valid <= 1'b0;
      rx_frame_end <= 1'b1;
      @(posedge aclk);
      rx_frame_end <= 1'b0;
   endtask
endmodule

// ---- verification/tb_rfb_top.sv ----
// Self-checking bench for the reader buffer and bit framing block
`timescale 1ns/1ps
module tb_rfb_top
   import rfb_pkg::*;
;
   logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, slow = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, irq;
   logic        tx_bit, tx_bit_valid, tx_bit_ready;
   logic        rx_bit, rx_bit_valid, rx_frame_end;
   logic        timer_go_strobe, timer_halt_strobe;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [2:0]  link_state_code;
   int          mismatches = 0, n_checks = 0, n_go = 0, n_halt = 0;

   always #4 aclk = ~aclk;

   rfb_top u_dut (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready,
      .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
      .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .tx_bit, .tx_bit_valid, .tx_bit_ready, .rx_bit, .rx_bit_valid,
      .rx_frame_end, .timer_go_strobe, .timer_halt_strobe,
      .link_state_code, .irq);

   rfb_modem_model u_mdm (.aclk, .aresetn, .slow, .tx_bit,
      .tx_bit_valid, .tx_bit_ready, .rx_bit, .rx_bit_valid,
      .rx_frame_end);

   always @(posedge aclk) begin
      if (timer_go_strobe === 1'b1) n_go++;
      if (timer_halt_strobe === 1'b1) n_halt++;
   end

   function automatic logic [7:0] ad(input logic [5:0] i);
      return {i, 2'b00};
   endfunction

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, d, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, d};
      wstrb <= 4'h1;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk($sformatf("bresp@%h", a), {30'h0, er}, {30'h0, bresp});
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] m, e,
                     input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk($sformatf("rdata@%h", a), e, rdata & m);
      chk($sformatf("rresp@%h", a), {30'h0, er}, {30'h0, rresp});
   endtask

   task automatic rq(input logic [7:0] a, e);
      rd(a, 32'hffffffff, {24'h0, e}, RESP_OK);
   endtask

   task automatic wq(input logic [7:0] a, d);
      wr(a, d, RESP_OK);
   endtask

   task automatic t_reset;
      rq(ad(IDX_THR), 8'h08);
      rq(ad(IDX_LEVEL), 8'h00);
      rq(ad(IDX_CTRL), 8'h10);
      rq(ad(IDX_FRAME), 8'h00);
      rq(ad(IDX_ALERT), 8'h01);
      $display("test reset done");
   endtask

   task automatic t_fill;
      for (int i = 0; i <= 64; i++) begin
         rq(ad(IDX_ALERT), {6'h0, (64 - i) <= THR_RST, i <= THR_RST});
         rq(ad(IDX_LEVEL), 8'(i));
         if (i < 64) wq(ad(IDX_DATA), 8'(i + 48));
      end
      wq(ad(IDX_DATA), 8'hee);
      rq(ad(IDX_ERR), 8'h01);
      rq(ad(IDX_LEVEL), 8'h40);
      rd(ad(IDX_ISTAT), 32'h4, 32'h4, RESP_OK);
      rq(ad(IDX_DATA), 8'h30);
      rq(ad(IDX_DATA), 8'h31);
      rq(ad(IDX_LEVEL), 8'h3e);
      wq(ad(IDX_LEVEL), 8'h80);
      rq(ad(IDX_LEVEL), 8'h00);
      rq(ad(IDX_ERR), 8'h00);
      rd(ad(IDX_DATA), 32'h0, 32'h0, RESP_OK);
      rq(ad(IDX_LEVEL), 8'h00);
      $display("test fill done");
   endtask

   task automatic t_irq;
      chk("irq", 32'h0, irq);
      wq(ad(IDX_IMASK), 8'h04);
      chk("irq", 32'h1, irq);
      wq(ad(IDX_IMASK), 8'h07);
      wq(ad(IDX_ISTAT), 8'h04);
      chk("irq", 32'h0, irq);
      rq(ad(IDX_ISTAT), 8'h00);
      $display("test irq done");
   endtask

   task automatic t_strobe;
      wq(ad(IDX_CTRL), 8'hc0);
      repeat (3) @(posedge aclk);
      chk("go pulses", 32'h1, n_go);
      chk("halt pulses", 32'h1, n_halt);
      rq(ad(IDX_CTRL), 8'h10);
      $display("test strobe done");
   endtask

   task automatic t_tx;
      wq(ad(IDX_DATA), 8'ha5);
      wq(ad(IDX_DATA), 8'h3c);
      wq(ad(IDX_FRAME), 8'h83);
      rq(ad(IDX_LINK), 8'h00);
      rq(ad(IDX_LEVEL), 8'h02);
      wq(ad(IDX_CMD), 8'h01);
      rq(ad(IDX_LINK), 8'h01);
      slow <= 1'b1;
      // The receive offset is reloaded on every transmit-state cycle, so set it with the send here
      wq(ad(IDX_FRAME), 8'hf3);
      for (int n = 0; n < 400 && link_state_code !== ST_WAIT_DATA; n++)
         @(posedge aclk);
      chk("state", ST_WAIT_DATA, link_state_code);
      chk("tx count", 32'd11, u_mdm.ncap);
      chk("tx bits", {3'b100, 8'ha5}, u_mdm.cap[10:0]);
      rq(ad(IDX_FRAME), 8'h73);
      rd(ad(IDX_ISTAT), 32'h1, 32'h1, RESP_OK);
      chk("irq", 32'h1, irq);
      $display("test tx done");
   endtask

   task automatic t_rx;
      // Offset 7 only as the anticollision case uses it
      wq(ad(IDX_FRAME), 8'h70);
      u_mdm.send(16'h02b5, 10);
      repeat (3) @(posedge aclk);
      rq(ad(IDX_LEVEL), 8'h03);
      rd(ad(IDX_DATA), 32'h80, 32'h80, RESP_OK);
      rq(ad(IDX_DATA), 8'h5a);
      rd(ad(IDX_DATA), 32'h1, 32'h1, RESP_OK);
      rq(ad(IDX_CTRL), 8'h11);
      rq(ad(IDX_LINK), 8'h01);
      rd(ad(IDX_ISTAT), 32'h2, 32'h2, RESP_OK);
      wq(ad(IDX_FRAME), 8'h00);
      $display("test rx done");
   endtask

   task automatic t_err;
      rd(8'h3c, 32'hffffffff, 32'h0, RESP_ERR);
      wr(8'h25, 8'h01, RESP_ERR);
      rq(ad(IDX_THR), 8'h08);
      $display("test err done");
   endtask

   task automatic t_hold;
      // Clock enable low must stall the bus and hold the write until ce returns, when it lands
      ce <= 1'b0;
      fork
         wq(ad(IDX_THR), 8'h05);
         begin
            repeat (6) @(posedge aclk);
            chk("awready frozen", 32'h0, awready);
            chk("bvalid frozen", 32'h0, bvalid);
            ce <= 1'b1;
         end
      join
      rq(ad(IDX_THR), 8'h05);
      wq(ad(IDX_THR), {2'h0, THR_RST});
      $display("test hold done");
   endtask

   task results;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_fill();
      t_irq();
      t_strobe();
      t_tx();
      t_rx();
      t_err();
      t_hold();
      results();
   end

   initial begin
      repeat (20000) @(posedge aclk);
      mismatches++;
      results();
   end
endmodule

// ---- verilog/rfb_byte_fifo.sv ----
// Byte buffer with fill count, overflow pulse and pointer clear
`timescale 1ns/1ps
module rfb_byte_fifo
   import rfb_pkg::*;
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       ce,
   input  wire logic       clear,
   input  wire logic       push,
   input  wire logic [7:0] push_data,
   input  wire logic       pop,
   output logic      [7:0] head,
   output logic      [6:0] fill,
   output logic            overflow
);
   logic [7:0] mem [0:63];
   logic [5:0] wr_ptr;
   logic [5:0] rd_ptr;
   logic       pop_ok;
   logic       push_ok;

   // An empty pop changes nothing; a full push is allowed only with a pop
   assign pop_ok   = pop && (fill != 7'h00);
   assign push_ok  = push && ((fill != FIFO_DEPTH) || pop_ok);
   assign overflow = ce && push && !push_ok;
   assign head     = mem[rd_ptr];

   always_ff @(posedge aclk) begin
      if (ce && push_ok && !clear) begin
         mem[wr_ptr] <= push_data;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_ptr <= 6'h00;
         rd_ptr <= 6'h00;
         fill   <= 7'h00;
      end else if (ce) begin
         if (clear) begin
            wr_ptr <= 6'h00;
            rd_ptr <= 6'h00;
            fill   <= 7'h00;
         end else begin
            if (push_ok) begin
               wr_ptr <= wr_ptr + 6'h01;
            end
            if (pop_ok) begin
               rd_ptr <= rd_ptr + 6'h01;
            end
            if (push_ok && !pop_ok) begin
               fill <= fill + 7'h01;
            end else if (pop_ok && !push_ok) begin
               fill <= fill - 7'h01;
            end
         end
      end
   end
endmodule

// ---- verilog/rfb_pkg.sv ----
// Constants and types for the reader buffer and bit framing block
// Behaviour
// - One byte-wide data port writes into and reads from a 64-byte buffer.
// - The buffer feeds bytes to the transmitter and collects received bytes.
// - Writing 1 to pointer_clear resets both pointers and clears overflow.
// - Reading the pointer_clear bit always returns 0.
// - A 7-bit fill count rises on port writes and falls on port reads.
// - near_full_flag is 1 while free space is at most the threshold.
// - near_empty_flag is 1 while the fill count is at most the threshold.
// - Writing 1 to timer_halt_strobe stops the timer; it reads back 0.
// - Writing 1 to timer_go_strobe starts the timer; it reads back 0.
// - A 3-bit field gives valid bits of the last received byte; 0 is all.
// - send_trigger starts sending only while transceive is active.
// - rx_bit_offset sets where the first received bit lands; others follow.
// - With offset 7 the second bit goes to bit 0 of the next byte.
// - tx_final_bit_count sets bits sent of the last byte; 0 sends all.
// - The link state machine shows code 001 while awaiting send_trigger.
package rfb_pkg;
   localparam logic [5:0] IDX_CMD    = 6'h01;
   localparam logic [5:0] IDX_IMASK  = 6'h02;
   localparam logic [5:0] IDX_ISTAT  = 6'h04;
   localparam logic [5:0] IDX_ERR    = 6'h06;
   localparam logic [5:0] IDX_ALERT  = 6'h07;
   localparam logic [5:0] IDX_LINK   = 6'h08;
   localparam logic [5:0] IDX_DATA   = 6'h09;
   localparam logic [5:0] IDX_LEVEL  = 6'h0a;
   localparam logic [5:0] IDX_THR    = 6'h0b;
   localparam logic [5:0] IDX_CTRL   = 6'h0c;
   localparam logic [5:0] IDX_FRAME  = 6'h0d;
   localparam logic [6:0] FIFO_DEPTH = 7'h40;
   localparam logic [5:0] THR_RST    = 6'h08;
   localparam logic [7:0] CTRL_RSV   = 8'h10;
   localparam logic [3:0] BYTE_BITS  = 4'h8;
   localparam logic [1:0] RESP_OK    = 2'h0;
   localparam logic [1:0] RESP_ERR   = 2'h2;
   localparam int B_FLUSH = 7;
   localparam int B_HALT  = 7;
   localparam int B_GO    = 6;
   localparam int B_SEND  = 7;
   localparam int P_ALIGN = 4;
   localparam int B_TRX   = 0;
   localparam int IRQ_TX  = 0;
   localparam int IRQ_RX  = 1;
   localparam int IRQ_OVF = 2;
   localparam int IRQ_W   = 3;
   typedef enum logic [2:0] {
      ST_IDLE      = 3'b000,
      ST_WAIT_SEND = 3'b001,
      ST_TRANSMIT  = 3'b011,
      ST_WAIT_DATA = 3'b101,
      ST_RECEIVE   = 3'b110
   } rfb_state_t;
endpackage

// ---- verilog/rfb_top.sv ----
// Buffer, alert levels, timer strobes and bit framing behind AXI4-Lite
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
module rfb_top
   import rfb_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   output logic             tx_bit,
   output logic             tx_bit_valid,
   input  wire logic        tx_bit_ready,
   input  wire logic        rx_bit,
   input  wire logic        rx_bit_valid,
   input  wire logic        rx_frame_end,
   output logic             timer_go_strobe,
   output logic             timer_halt_strobe,
   output logic [2:0]       link_state_code,
   output logic             irq
);
   rfb_state_t state;
   logic       aw_hold, aw_bad, w_hold, w_lane, wr_fire, wr_ok;
   logic [5:0] aw_idx, ar_idx, rd_idx;
   logic [7:0] w_byte, rd_val;
   logic       ar_fire, rd_ok;
   logic       transceive;
   logic [5:0] alert_threshold;
   logic [2:0] rx_bit_offset, tx_final_bit_count, rx_final_valid_bits;
   logic       overflow_error, near_full_flag, near_empty_flag;
   logic [IRQ_W-1:0] irq_stat, irq_mask, irq_evt;
   logic       host_push, host_pop, link_push, link_pop;
   logic       pointer_clear, send_trigger, ovf_evt;
   logic [7:0] head, push_byte, rx_sr;
   logic [6:0] fill_count;
   logic [3:0] tx_cnt;
   logic [7:0] tx_sr;
   logic       tx_busy, tx_take, tx_done;
   logic [2:0] rx_pos;
   logic       rx_any, rx_take, rx_end;

   function automatic logic is_mapped(input logic [5:0] idx);
      case (idx)
         IDX_CMD, IDX_IMASK, IDX_ISTAT, IDX_ERR, IDX_ALERT, IDX_LINK,
         IDX_DATA, IDX_LEVEL, IDX_THR, IDX_CTRL, IDX_FRAME:
            is_mapped = 1'b1;
         default:
            is_mapped = 1'b0;
      endcase
   endfunction

   function automatic logic [7:0] put_bit(input logic [7:0] sr,
                                          input logic [2:0] pos,
                                          input logic       b);
      put_bit      = sr;
      put_bit[pos] = b;
   endfunction

   // Write channel: address and data are held until both have arrived
   assign awready = ce && !aw_hold;
   assign wready  = ce && !w_hold;
   assign wr_fire = ce && aw_hold && w_hold && !bvalid;
   assign wr_ok   = wr_fire && !aw_bad && is_mapped(aw_idx) && w_lane;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold <= 1'b0;
         aw_idx  <= 6'h00;
         aw_bad  <= 1'b0;
      end else if (ce) begin
         if (awvalid && awready) begin
            aw_hold <= 1'b1;
            aw_idx  <= awaddr[7:2];
            aw_bad  <= awaddr[1:0] != 2'h0;
         end else if (wr_fire) begin
            aw_hold <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_hold <= 1'b0;
         w_byte <= 8'h00;
         w_lane <= 1'b0;
      end else if (ce) begin
         if (wvalid && wready) begin
            w_hold <= 1'b1;
            w_byte <= wdata[7:0];
            w_lane <= wstrb[0];
         end else if (wr_fire) begin
            w_hold <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp  <= RESP_OK;
      end else if (ce) begin
         if (wr_fire) begin
            bvalid <= 1'b1;
            bresp  <= (aw_bad || !is_mapped(aw_idx)) ? RESP_ERR : RESP_OK;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // Read channel: one read in flight, data port reads pop the buffer
   assign arready  = ce && !rvalid;
   assign ar_fire  = arvalid && arready;
   assign ar_idx   = araddr[7:2];
   assign rd_ok    = (araddr[1:0] == 2'h0) && is_mapped(ar_idx);
   assign host_pop = ar_fire && rd_ok && (ar_idx == IDX_DATA);

   always_comb begin
      case (ar_idx)
         IDX_CMD:   rd_val = {7'h00, transceive};
         IDX_IMASK: rd_val = {5'h00, irq_mask};
         IDX_ISTAT: rd_val = {5'h00, irq_stat};
         IDX_ERR:   rd_val = {7'h00, overflow_error};
         IDX_ALERT: rd_val = {6'h00, near_full_flag, near_empty_flag};
         IDX_LINK:  rd_val = {5'h00, link_state_code};
         IDX_DATA:  rd_val = head;
         IDX_LEVEL: rd_val = {1'b0, fill_count};
         IDX_THR:   rd_val = {2'h0, alert_threshold};
         IDX_CTRL:  rd_val = CTRL_RSV | {5'h00, rx_final_valid_bits};
         IDX_FRAME: rd_val = {1'b0, rx_bit_offset, 1'b0, tx_final_bit_count};
         default:   rd_val = 8'h00;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rresp  <= RESP_OK;
         rdata  <= 32'h0000_0000;
         rd_idx <= 6'h00;
      end else if (ce) begin
         if (ar_fire) begin
            rvalid <= 1'b1;
            rresp  <= rd_ok ? RESP_OK : RESP_ERR;
            rdata  <= rd_ok ? {24'h00_0000, rd_val} : 32'h0000_0000;
            rd_idx <= ar_idx;
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   // Write side effects
   assign host_push     = wr_ok && (aw_idx == IDX_DATA);
   assign pointer_clear = wr_ok && (aw_idx == IDX_LEVEL) && w_byte[B_FLUSH];
   assign send_trigger  = wr_ok && (aw_idx == IDX_FRAME) && w_byte[B_SEND];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         transceive         <= 1'b0;
         irq_mask           <= '0;
         alert_threshold    <= THR_RST;
         rx_bit_offset      <= 3'h0;
         tx_final_bit_count <= 3'h0;
      end else if (ce && wr_ok) begin
         unique case (aw_idx)
            IDX_CMD:   transceive <= w_byte[B_TRX];
            IDX_IMASK: irq_mask <= w_byte[IRQ_W-1:0];
            IDX_THR:   alert_threshold <= w_byte[5:0];
            IDX_FRAME: begin
               rx_bit_offset      <= w_byte[P_ALIGN+2:P_ALIGN];
               tx_final_bit_count <= w_byte[2:0];
            end
            default: begin
            end
         endcase
      end
   end

   // Strobes last one cycle and never read back as ones
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer_go_strobe   <= 1'b0;
         timer_halt_strobe <= 1'b0;
      end else if (ce) begin
         timer_go_strobe   <= wr_ok && (aw_idx == IDX_CTRL) && w_byte[B_GO];
         timer_halt_strobe <= wr_ok && (aw_idx == IDX_CTRL)
                              && w_byte[B_HALT];
      end
   end

   // Host access wins a clash; a received byte in the same cycle is lost
   assign push_byte = host_push ? w_byte
                    : (rx_take ? put_bit(rx_sr, rx_pos, rx_bit) : rx_sr);

   rfb_byte_fifo u_fifo (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .ce        (ce),
      .clear     (pointer_clear),
      .push      (host_push || link_push),
      .push_data (push_byte),
      .pop       (host_pop || link_pop),
      .head      (head),
      .fill      (fill_count),
      .overflow  (ovf_evt)
   );

   assign near_full_flag  = (FIFO_DEPTH - fill_count)
                            <= {1'b0, alert_threshold};
   assign near_empty_flag = fill_count <= {1'b0, alert_threshold};

   // Overflow is sticky; a new overflow beats a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         overflow_error <= 1'b0;
      end else if (ce) begin
         if (ovf_evt) begin
            overflow_error <= 1'b1;
         end else if (pointer_clear) begin
            overflow_error <= 1'b0;
         end
      end
   end

   // Link state machine
   assign link_state_code = state;
   assign tx_done = (state == ST_TRANSMIT) && !tx_busy
                    && (fill_count == 7'h00) && !host_push;
   assign rx_take = ((state == ST_WAIT_DATA) || (state == ST_RECEIVE))
                    && rx_bit_valid;
   assign rx_end  = (state == ST_RECEIVE) && rx_frame_end && !rx_bit_valid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= ST_IDLE;
      end else if (ce) begin
         if (!transceive) begin
            state <= ST_IDLE;
         end else begin
            unique case (state)
               ST_IDLE:      state <= ST_WAIT_SEND;
               ST_WAIT_SEND: if (send_trigger) begin
                  state <= ST_TRANSMIT;
               end
               ST_TRANSMIT:  if (tx_done) begin
                  state <= ST_WAIT_DATA;
               end
               ST_WAIT_DATA: if (rx_take) begin
                  state <= ST_RECEIVE;
               end
               ST_RECEIVE:   if (rx_end) begin
                  state <= ST_WAIT_SEND;
               end
            endcase
         end
      end
   end

   // Transmit: bytes leave the buffer and go out least significant first
   assign tx_bit_valid = tx_busy;
   assign tx_bit       = tx_sr[0];
   assign tx_take      = ce && tx_busy && tx_bit_ready;
   assign link_pop     = (state == ST_TRANSMIT) && !tx_busy
                         && (fill_count != 7'h00) && !host_pop;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_busy <= 1'b0;
         tx_sr   <= 8'h00;
         tx_cnt  <= 4'h0;
      end else if (ce) begin
         if (state != ST_TRANSMIT) begin
            tx_busy <= 1'b0;
         end else if (link_pop) begin
            tx_busy <= 1'b1;
            tx_sr   <= head;
            if ((fill_count == 7'h01) && (tx_final_bit_count != 3'h0)) begin
               tx_cnt <= {1'b0, tx_final_bit_count};
            end else begin
               tx_cnt <= BYTE_BITS;
            end
         end else if (tx_take) begin
            tx_sr  <= {1'b0, tx_sr[7:1]};
            tx_cnt <= tx_cnt - 4'h1;
            if (tx_cnt == 4'h1) begin
               tx_busy <= 1'b0;
            end
         end
      end
   end

   // Receive: bits fill bytes from the chosen offset upward
   assign link_push = (rx_take && (rx_pos == 3'h7))
                      || (rx_end && rx_any);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_sr               <= 8'h00;
         rx_pos              <= 3'h0;
         rx_any              <= 1'b0;
         rx_final_valid_bits <= 3'h0;
      end else if (ce) begin
         if (state == ST_TRANSMIT) begin
            rx_sr  <= 8'h00;
            rx_pos <= rx_bit_offset;
            rx_any <= 1'b0;
         end else if (rx_take) begin
            rx_sr  <= (rx_pos == 3'h7) ? 8'h00
                    : put_bit(rx_sr, rx_pos, rx_bit);
            rx_pos <= rx_pos + 3'h1;
            rx_any <= rx_pos != 3'h7;
         end else if (rx_end) begin
            rx_final_valid_bits <= rx_any ? rx_pos : 3'h0;
         end
      end
   end

   // Interrupt status: set wins over a write-one clear
   assign irq_evt = {ovf_evt, rx_end, tx_done};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat <= '0;
      end else if (ce) begin
         if (wr_ok && (aw_idx == IDX_ISTAT)) begin
            irq_stat <= (irq_stat & ~w_byte[IRQ_W-1:0]) | irq_evt;
         end else begin
            irq_stat <= irq_stat | irq_evt;
         end
      end
   end

   assign irq = |(irq_stat & irq_mask);

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_flush;
      ce && pointer_clear && !ovf_evt;
   endsequence
   sequence s_full_write;
      ce && host_push && (fill_count == FIFO_DEPTH) && !link_pop && !host_pop;
   endsequence
   sequence s_idle_send;
      ce && (state == ST_IDLE) && send_trigger;
   endsequence

   flush_clear_a: assert property (s_flush |=> (fill_count == 7'h00)
      && !overflow_error) else $error("flush left data or overflow");
   level_read_a: assert property (rvalid && (rd_idx == IDX_LEVEL)
      |-> !rdata[B_FLUSH]) else $error("flush bit read as one");
   fill_step_a: assert property (ce && host_push && !link_pop
      && !host_pop && (fill_count < FIFO_DEPTH) && !pointer_clear
      |=> fill_count == $past(fill_count) + 7'h01)
      else $error("fill count did not rise");
   alert_high_a: assert property ((fill_count >= 7'h38)
      && (alert_threshold == THR_RST) |-> near_full_flag)
      else $error("near full flag missing");
   alert_low_a: assert property ((fill_count == {1'b0, alert_threshold})
      |-> near_empty_flag) else $error("near empty flag missing");
   strobe_pulse_a: assert property (ce && timer_go_strobe
      |=> !timer_go_strobe) else $error("timer strobe held");
   send_gate_a: assert property (s_idle_send
      |=> state != ST_TRANSMIT) else $error("send began without transceive");
   wait_code_a: assert property (ce && transceive && (state == ST_IDLE)
      |=> link_state_code == 3'b001) else $error("wait code wrong");
   overflow_set_a: assert property (s_full_write |=> overflow_error
      && (fill_count == FIFO_DEPTH)) else $error("overflow missed");
   empty_read_a: assert property (ce && host_pop
      && (fill_count == 7'h00) && !host_push && !link_push
      |=> fill_count == 7'h00) else $error("empty read moved count");
endmodule
